//--- fbp_nv_model.sv
// nonvolatile store model for the one-time lock bit
`timescale 1ns/1ps
module fbp_nv_model (
   input  wire logic i_sys_clk,
   input  wire logic i_otp_nv_write, // one-cycle program pulse
   output logic      o_otp_nv        // stored bit
);
   logic nv_reg = 1'b0; // blank part is unprotected
   // no reset on purpose: the bit has to outlive every reset
   always_ff @(posedge i_sys_clk) begin
      if (i_otp_nv_write) nv_reg <= 1'b1;
   end
   assign o_otp_nv = nv_reg;
endmodule

//--- fbp_pkg.sv
// package: constants and carriers for the flash block protection logic
package fbp_pkg;
   localparam int unsigned ADDR_W       = 20;  // 32-bit word address width
   localparam int unsigned BLK_W        = 7;   // block index width
   localparam int unsigned NUM_BLK      = 74;  // blocks in the array
   localparam logic [19:0] LOCK1_ADDR   = 20'h000AA;
   localparam logic [7:0]  LOCK1_DATA   = 8'h49;
   localparam logic [19:0] LOCK2_ADDR   = 20'h00003;
   localparam logic [31:0] LOCK2_DATA   = 32'h00000000;
   // otp covered ranges
   localparam logic [19:0] OTP_BOT_LO   = 20'h01000;
   localparam logic [19:0] OTP_BOT_HI   = 20'h01FFF;
   localparam logic [19:0] OTP_T32_LO   = 20'hFE000;
   localparam logic [19:0] OTP_T32_HI   = 20'hFEFFF;
   localparam logic [19:0] OTP_T16_LO   = 20'h7E000;
   localparam logic [19:0] OTP_T16_HI   = 20'h7EFFF;
   // status values
   localparam logic [7:0]  SR_READY     = 8'h80;
   localparam logic [7:0]  SR_BUSY      = 8'h00;
   localparam logic [7:0]  SR_ERASE_OTP = 8'hA3;
   localparam logic [7:0]  SR_PROG_OTP  = 8'h93;
   localparam logic [7:0]  SR_BAD_SEQ   = 8'hB1;
   localparam logic [7:0]  SR_PROT_ERR  = 8'h82;  // block protected error
   localparam logic [7:0]  SR_PEN_ERR   = 8'h88;  // program/erase disabled
   localparam logic [7:0]  SR_CLEAR     = 8'h00;
   // lock operation time
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned LOCK_TIME_US = 35;
   localparam int unsigned LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;
   localparam logic [11:0] LOCK_CYC_W   = 12'(LOCK_CYC);

   // request kinds from the command decoder
   typedef enum logic [2:0] {
      FBP_CMD_PROG  = 3'h0,
      FBP_CMD_ERASE = 3'h1,
      FBP_CMD_SETP  = 3'h2,
      FBP_CMD_CLRP  = 3'h3,
      FBP_CMD_CLRSR = 3'h4,
      FBP_CMD_SUSP  = 3'h5,
      FBP_CMD_WRITE = 3'h6
   } fbp_cmd_t;

   // one bus write cycle handed over by the command decoder
   typedef struct packed {
      fbp_cmd_t          cmd;
      logic [BLK_W-1:0]  blk;
      logic [19:0]       addr;
      logic [31:0]       data;
   } fbp_req_t;

   // result towards the array controller
   typedef struct packed {
      logic              go;
      logic              erase;
      logic [BLK_W-1:0]  blk;
   } fbp_grant_t;
endpackage

//--- fbp_protect.sv
// flash block protection gate with one-time lock of parameter blocks
`timescale 1ns/1ps
module fbp_protect
   import fbp_pkg::*;
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_reset_powerdown_n, // pin, active low
   input  wire logic             i_program_erase_enable, // pin
   input  wire logic             i_wp_n,              // write-protect pin
   input  wire logic             i_is_top,            // boot orientation
   input  wire logic             i_is_32m,            // density strap
   input  wire logic             i_otp_nv,            // stored otp bit
   input  wire logic             i_req_valid,         // one-cycle pulse
   input  wire fbp_req_t         i_req,
   output logic                  o_otp_nv_write,      // program nv bit
   output logic                  o_otp_locked,
   output logic                  o_busy,
   output fbp_grant_t            o_grant,
   output logic [7:0]            o_op_status_reg
);
   typedef enum logic [1:0] {
      FBP_IDLE  = 2'b00,   // waiting for commands
      FBP_ARMED = 2'b01,   // first lock cycle seen
      FBP_LOCK  = 2'b10    // nv write in progress
   } fbp_state_t;

   // pin synchronisers, first stage read only by second
   logic [1:0] rp_sync_reg, pen_sync_reg, wp_sync_reg;
   logic [1:0] top_sync_reg, m32_sync_reg; // straps are pins as well
   logic       rp_ok, pen_ok, wp_low;
   logic [NUM_BLK-1:0] prot_reg;          // volatile per-block pattern
   logic       otp_reg;                   // mirror of nv bit
   logic       otp_seen_reg;              // nv bit caught after release
   fbp_state_t state_reg;
   logic [11:0] cnt_reg;                  // lock timer
   logic       otp_hit, blk_prot, is_mod;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rp_sync_reg  <= 2'b00;
         pen_sync_reg <= 2'b00;
         wp_sync_reg  <= 2'b00;
         top_sync_reg <= 2'b00;
         m32_sync_reg <= 2'b00;
      end else begin
         rp_sync_reg  <= {rp_sync_reg[0], i_reset_powerdown_n};
         pen_sync_reg <= {pen_sync_reg[0], i_program_erase_enable};
         wp_sync_reg  <= {wp_sync_reg[0], i_wp_n};
         // strap decode settles while the reset pin sync still blocks work
         top_sync_reg <= {top_sync_reg[0], i_is_top};
         m32_sync_reg <= {m32_sync_reg[0], i_is_32m};
      end
   end
   assign rp_ok  = rp_sync_reg[1];
   assign pen_ok = pen_sync_reg[1];
   assign wp_low = !wp_sync_reg[1];

   // otp address decode by density and orientation
   always_comb begin
      if (!top_sync_reg[1])
         otp_hit = i_req.addr >= OTP_BOT_LO && i_req.addr <= OTP_BOT_HI;
      else if (m32_sync_reg[1])
         otp_hit = i_req.addr >= OTP_T32_LO && i_req.addr <= OTP_T32_HI;
      else
         otp_hit = i_req.addr >= OTP_T16_LO && i_req.addr <= OTP_T16_HI;
   end

   // pattern applies only while write-protect is low
   assign blk_prot = wp_low && prot_reg[i_req.blk];
   assign is_mod   = i_req_valid && (i_req.cmd == FBP_CMD_PROG ||
                                     i_req.cmd == FBP_CMD_ERASE);

   // protection pattern: all set at power-up and while reset pin low
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prot_reg <= '1;
      end else if (!rp_ok) begin
         prot_reg <= '1;
      end else if (i_req_valid && state_reg == FBP_IDLE) begin
         if (i_req.cmd == FBP_CMD_SETP)
            prot_reg[i_req.blk] <= 1'b1;
         else if (i_req.cmd == FBP_CMD_CLRP)
            prot_reg[i_req.blk] <= 1'b0;
      end
   end

   // otp mirror: sticky, only ever set
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         otp_reg      <= 1'b0;
         otp_seen_reg <= 1'b0;
      end else begin
         otp_seen_reg <= 1'b1;
         // nv bit is sampled once after reset release
         if (!otp_seen_reg && i_otp_nv)
            otp_reg <= 1'b1;
         else if (state_reg == FBP_LOCK && cnt_reg == 12'h001)
            otp_reg <= 1'b1;
      end
   end

   // lock sequencer, status and grant
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg       <= FBP_IDLE;
         cnt_reg         <= 12'h000;
         o_op_status_reg <= SR_CLEAR;
         o_grant         <= '0;
         o_otp_nv_write  <= 1'b0;
         o_busy          <= 1'b0;
      end else begin
         o_grant        <= '0;
         o_otp_nv_write <= 1'b0;
         if (!rp_ok) begin
            // reset pin low: nothing runs, status cleared
            state_reg       <= FBP_IDLE;
            cnt_reg         <= 12'h000;
            o_op_status_reg <= SR_CLEAR;
            o_busy          <= 1'b0;
         end else begin
            unique case (state_reg)
               FBP_IDLE: begin
                  if (i_req_valid && i_req.cmd == FBP_CMD_CLRSR) begin
                     o_op_status_reg <= SR_READY;
                  end else if (i_req_valid && i_req.cmd == FBP_CMD_WRITE &&
                               i_req.addr == LOCK1_ADDR &&
                               i_req.data[7:0] == LOCK1_DATA) begin
                     state_reg <= FBP_ARMED;
                  end else if (is_mod) begin
                     if (!pen_ok)
                        o_op_status_reg <= SR_PEN_ERR;
                     else if (otp_reg && otp_hit)
                        o_op_status_reg <= (i_req.cmd == FBP_CMD_ERASE) ?
                                           SR_ERASE_OTP : SR_PROG_OTP;
                     else if (blk_prot)
                        o_op_status_reg <= SR_PROT_ERR;
                     else begin
                        o_grant.go    <= 1'b1;
                        o_grant.erase <= (i_req.cmd == FBP_CMD_ERASE);
                        o_grant.blk   <= i_req.blk;
                     end
                  end
               end
               FBP_ARMED: begin
                  if (i_req_valid) begin
                     if (i_req.addr == LOCK2_ADDR &&
                         i_req.data == LOCK2_DATA) begin
                        // write-protect high is the host's duty
                        state_reg       <= FBP_LOCK;
                        cnt_reg         <= LOCK_CYC_W;
                        o_op_status_reg <= SR_BUSY;
                        o_busy          <= 1'b1;
                        o_otp_nv_write  <= 1'b1;
                     end else begin
                        state_reg       <= FBP_IDLE;
                        o_op_status_reg <= SR_BAD_SEQ;
                     end
                  end
               end
               FBP_LOCK: begin
                  // suspends and new commands are dropped here
                  if (cnt_reg == 12'h001) begin
                     state_reg       <= FBP_IDLE;
                     o_op_status_reg <= SR_READY;
                     o_busy          <= 1'b0;
                  end
                  cnt_reg <= cnt_reg - 12'h001;
               end
               default: state_reg <= FBP_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn)
         o_otp_locked <= 1'b0;
      else
         o_otp_locked <= otp_reg;
   end

   otp_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      $past(otp_reg) |-> otp_reg) else $error("otp cleared");
   no_grant_rp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      !rp_sync_reg[1] |=> !o_grant.go) else $error("grant in reset");
   pen_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg == FBP_IDLE && rp_ok && is_mod && !pen_ok
      |=> o_op_status_reg == SR_PEN_ERR && !o_grant.go)
      else $error("pen error missing");
   otp_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg == FBP_IDLE && rp_ok && is_mod && pen_ok && otp_reg && otp_hit
      |=> !o_grant.go && (o_op_status_reg == SR_ERASE_OTP ||
          o_op_status_reg == SR_PROG_OTP)) else $error("otp write");
   prot_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg == FBP_IDLE && rp_ok && is_mod && pen_ok && !otp_hit &&
      blk_prot |=> o_op_status_reg == SR_PROT_ERR && !o_grant.go)
      else $error("protected block granted");
   bad_seq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg == FBP_ARMED && rp_ok && i_req_valid &&
      i_req.addr != LOCK2_ADDR |=> o_op_status_reg == SR_BAD_SEQ &&
      otp_reg == $past(otp_reg))
      else $error("bad sequence not flagged");
   lock_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      state_reg == FBP_LOCK |-> !o_grant.go) else $error("grant in lock");
   rp_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      !rp_ok |=> o_op_status_reg == SR_CLEAR && &prot_reg)
      else $error("reset pin no clear");
endmodule

//--- fbp_protect_tb.sv
// self-checking testbench for the block protection gate
`timescale 1ns/1ps
module fbp_protect_tb;
   import fbp_pkg::*;
   logic       clk, rstn, rp_n, program_erase_enable, wp_n, top, m32, nv, vld; // pins
   fbp_req_t   req;                                           // request
   logic       nv_wr, locked, busy;                           // results
   fbp_grant_t grant;
   fbp_grant_t gnt_seen;  // grant pulse caught while it stands
   logic       nv_seen;   // nv program pulse caught while it stands
   logic [7:0] sr;
   int         n_errors, tests_run;
   int         i;

   fbp_protect dut (.i_sys_clk(clk), .i_rstn(rstn),
      .i_reset_powerdown_n(rp_n), .i_program_erase_enable(program_erase_enable),
      .i_wp_n(wp_n), .i_is_top(top), .i_is_32m(m32), .i_otp_nv(nv),
      .i_req_valid(vld), .i_req(req), .o_otp_nv_write(nv_wr),
      .o_otp_locked(locked), .o_busy(busy), .o_grant(grant),
      .o_op_status_reg(sr));
   fbp_nv_model nv_store (.i_sys_clk(clk), .i_otp_nv_write(nv_wr),
      .o_otp_nv(nv));

   // free running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle request, then sample the registered answer
   task automatic send(input fbp_cmd_t c, input logic [19:0] a,
                       input logic [31:0] d, input logic [6:0] b);
      req = '{cmd: c, blk: b, addr: a, data: d};
      vld = 1'b1;
      cyc(1);
      // pulses last one cycle, so catch them right after the taking edge
      gnt_seen = grant;
      nv_seen  = nv_wr;
      vld = 1'b0;
      cyc(1);
   endtask

   // blocks come up protected, then the pattern is edited
   task automatic t_pattern();
      wp_n = 1'b0;
      cyc(3); // pin synchroniser latency
      send(FBP_CMD_PROG, 20'h10000, 32'h0, 7'h04);
      chk1(gnt_seen.go, 1'b0);
      chk8(sr, SR_PROT_ERR);
      send(FBP_CMD_CLRP, 20'h0, 32'h0, 7'h04);
      send(FBP_CMD_PROG, 20'h10000, 32'h0, 7'h04);
      chk1(gnt_seen.go, 1'b1);
      chk8({1'b0, gnt_seen.blk}, 8'h04);
      send(FBP_CMD_PROG, 20'h14000, 32'h0, 7'h05);
      chk8(sr, SR_PROT_ERR);
      chk1(gnt_seen.go, 1'b0);
      send(FBP_CMD_SETP, 20'h0, 32'h0, 7'h04);
      send(FBP_CMD_PROG, 20'h10000, 32'h0, 7'h04);
      chk1(gnt_seen.go, 1'b0);
      wp_n = 1'b1;
      cyc(3);
      send(FBP_CMD_PROG, 20'h14000, 32'h0, 7'h05);
      chk1(gnt_seen.go, 1'b1);
   endtask
   // enable pin low, then reset pin low
   task automatic t_pins();
      program_erase_enable = 1'b0;
      cyc(3);
      send(FBP_CMD_ERASE, 20'h14000, 32'h0, 7'h05);
      chk1(gnt_seen.go, 1'b0);
      chk8(sr, SR_PEN_ERR);
      program_erase_enable = 1'b1;
      rp_n = 1'b0;
      cyc(3);
      send(FBP_CMD_PROG, 20'h14000, 32'h0, 7'h05);
      chk1(gnt_seen.go, 1'b0);
      chk8(sr, SR_CLEAR);
      rp_n = 1'b1;
      cyc(3);
   endtask
   // wrong second address aborts, clear-status recovers
   task automatic t_bad_seq();
      send(FBP_CMD_WRITE, LOCK1_ADDR, {24'h0, LOCK1_DATA}, 7'h00);
      send(FBP_CMD_WRITE, 20'h00004, LOCK2_DATA, 7'h00);
      chk8(sr, SR_BAD_SEQ);
      chk1(locked, 1'b0);
      send(FBP_CMD_CLRSR, 20'h0, 32'h0, 7'h00);
      chk8(sr, SR_READY);
   endtask
   // full lock with write-protect high, suspend and program refused
   task automatic t_lock();
      send(FBP_CMD_WRITE, LOCK1_ADDR, {24'h0, LOCK1_DATA}, 7'h00);
      send(FBP_CMD_WRITE, LOCK2_ADDR, LOCK2_DATA, 7'h00);
      chk8(sr, SR_BUSY);
      chk1(busy, 1'b1);
      chk1(nv_seen, 1'b1);
      send(FBP_CMD_SUSP, 20'h0, 32'h0, 7'h00);
      chk1(busy, 1'b1);
      chk8(sr, SR_BUSY);
      send(FBP_CMD_PROG, 20'h14000, 32'h0, 7'h05);
      chk1(gnt_seen.go, 1'b0);
      // bounded poll; 5 cycles of busy were already spent above
      for (i = 0; i < 4000 && busy === 1'b1; i++) cyc(1);
      if (busy !== 1'b0) begin
         n_errors++;
         $display("wrong value at %0t: lock never finished", $time);
         complete_run();
      end
      chk1(i == LOCK_CYC - 5, 1'b1);
      chk8(sr, SR_READY);
      cyc(1);
      chk1(locked, 1'b1);
   endtask
   // covered ranges per strap setting, then persistence over reset
   task automatic t_ranges();
      send(FBP_CMD_ERASE, OTP_T32_LO, 32'h0, 7'h48);
      chk8(sr, SR_ERASE_OTP);
      send(FBP_CMD_PROG, OTP_T32_HI, 32'h0, 7'h48);
      chk8(sr, SR_PROG_OTP);
      m32 = 1'b0;
      cyc(3); // strap synchroniser latency
      send(FBP_CMD_PROG, OTP_T16_LO, 32'h0, 7'h24);
      chk8(sr, SR_PROG_OTP);
      chk1(gnt_seen.go, 1'b0);
      top = 1'b0;
      cyc(3);
      send(FBP_CMD_PROG, OTP_BOT_HI, 32'h0, 7'h01);
      chk8(sr, SR_PROG_OTP);
      chk1(gnt_seen.go, 1'b0);
      send(FBP_CMD_PROG, 20'h02000, 32'h0, 7'h02);
      chk1(gnt_seen.go, 1'b1);
      rstn = 1'b0;
      cyc(2);
      rstn = 1'b1;
      cyc(4);
      chk1(locked, 1'b1);
      send(FBP_CMD_CLRSR, 20'h0, 32'h0, 7'h00);
      chk1(locked, 1'b1);
   endtask

   // main sequence
   initial begin
      n_errors = 0;
      tests_run = 0;
      {rstn, vld} = 2'b00;
      {rp_n, program_erase_enable, wp_n, top, m32} = 5'b11111;
      req = '0;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      cyc(4);
      t_pattern();
      t_pins();
      t_bad_seq();
      t_lock();
      t_ranges();
      complete_run();
   end
endmodule
